// >>> cal_alu_io.sv
// Execute-stage ALU with I/O register bit access
`timescale 1ns/1ns
`include "cal_alu_map.svh"
// ---------------------------------------------------------------
// How it works
// - Byte add, with or without carry, ZCNVH.
// - Byte register subtract, optional carry, ZCNVH.
// - Subtract immediate, one cycle, ZCNVH.
// - Subtract immediate with carry, ZCNVH.
// - Word add immediate, ZCNVS, two cycles.
// - Word subtract immediate, ZCNVS, two cycles.
// - AND register or immediate, ZNV only.
// - Bit set/clear only at ports 0..0x1F.
// - Skip tests on one bit, low range.
// - Writing one clears a status flag.
// - Bit set/clear touches only addressed bit.
// - Port in/out use addresses 0..0x3F.
// - Data-space address is port plus 0x20.
// ---------------------------------------------------------------
module cal_alu_io
  import cal_alu_pkg::*;
#(
  parameter int W1C_WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Decoded instruction
  input wire logic req_valid,
  input wire cal_req_t req,
  input wire logic [7:0] io_rd_data,
  output logic req_ready,
  // Results
  output logic res_valid,
  output logic [15:0] res_data,
  output logic res_wide,
  output logic [7:0] sreg,
  output logic skip,
  output logic addr_err,
  // I/O space write
  output cal_io_wr_t io_wr,
  // Hardware events of the flag register
  input wire logic [W1C_WIDTH-1:0] w1c_set,
  output logic [W1C_WIDTH-1:0] w1c_flags
);

  initial begin
    if (W1C_WIDTH < 1 || W1C_WIDTH > 8) $error("W1C_WIDTH must be 1 to 8");
  end

  // ---------------------------------------------------------------
  // Operand decode
  // ---------------------------------------------------------------
  logic take;
  logic [5:0] port;
  logic port_ok;
  logic bit_ok;
  logic [7:0] bit_mask;
  logic [7:0] io_val;
  logic [7:0] w1c_full;

  // Data-space forms are rebased to port numbers first
  always_comb begin
    take = req_valid && req_ready;
    w1c_full = 8'h00;
    w1c_full[W1C_WIDTH-1:0] = w1c_flags;
    bit_mask = 8'h01 << req.bit_sel;
    port = req.addr[5:0];
    port_ok = (req.addr <= {2'b00, `CAL_IO_PORT_LAST});
    if (req.op == CAL_OP_DATA_SPACE_LOAD || req.op == CAL_OP_DATA_SPACE_STORE) begin
      port = 6'(req.addr - `CAL_IO_DS_OFFSET);
      port_ok = (req.addr >= `CAL_IO_DS_OFFSET) && (req.addr <= `CAL_IO_DS_LAST);
    end
    bit_ok = (req.addr <= {2'b00, `CAL_IO_BIT_LAST});
    io_val = (port == `CAL_W1C_PORT) ? w1c_full : io_rd_data;
  end

  // ---------------------------------------------------------------
  // Byte and word arithmetic
  // ---------------------------------------------------------------
  logic [7:0] a;
  logic [7:0] b;
  logic cin;
  logic is_sub;
  logic is_byte_arith;
  logic [7:0] r8;
  logic [15:0] r16;
  logic [5:0] k6;
  logic word_sub;
  logic [7:0] flags8;

  // Flag equations follow carry-out and signed overflow of each bit slice
  always_comb begin
    a = req.rd;
    b = req.rr;
    cin = 1'b0;
    is_sub = 1'b0;
    is_byte_arith = 1'b1;
    case (req.op)
      CAL_OP_ADD: b = req.rr;
      CAL_OP_ADC: cin = sreg[`CAL_FLAG_C];
      CAL_OP_SUB: is_sub = 1'b1;
      CAL_OP_SUBTRACT_WITH_CARRY: begin
        is_sub = 1'b1;
        cin = sreg[`CAL_FLAG_C];
      end
      CAL_OP_SUBTRACT_IMMEDIATE: begin
        is_sub = 1'b1;
        b = req.imm;
      end
      CAL_OP_SUBTRACT_IMMEDIATE_WITH_CARRY: begin
        is_sub = 1'b1;
        b = req.imm;
        cin = sreg[`CAL_FLAG_C];
      end
      default: is_byte_arith = 1'b0;
    endcase
    r8 = is_sub ? 8'(a - b - {7'h00, cin}) : 8'(a + b + {7'h00, cin});
    flags8 = sreg;
    if (is_sub) begin
      flags8[`CAL_FLAG_H] = (~a[3] & b[3]) | (b[3] & r8[3]) | (r8[3] & ~a[3]);
      flags8[`CAL_FLAG_V] = (a[7] & ~b[7] & ~r8[7]) | (~a[7] & b[7] & r8[7]);
      flags8[`CAL_FLAG_C] = (~a[7] & b[7]) | (b[7] & r8[7]) | (r8[7] & ~a[7]);
    end else begin
      flags8[`CAL_FLAG_H] = (a[3] & b[3]) | (b[3] & ~r8[3]) | (~r8[3] & a[3]);
      flags8[`CAL_FLAG_V] = (a[7] & b[7] & ~r8[7]) | (~a[7] & ~b[7] & r8[7]);
      flags8[`CAL_FLAG_C] = (a[7] & b[7]) | (b[7] & ~r8[7]) | (~r8[7] & a[7]);
    end
    flags8[`CAL_FLAG_N] = r8[7];
    // Chained subtracts keep zero only if the whole multi-byte result is zero
    if (cin || req.op == CAL_OP_SUBTRACT_WITH_CARRY || req.op == CAL_OP_SUBTRACT_IMMEDIATE_WITH_CARRY)
      flags8[`CAL_FLAG_Z] = (r8 == 8'h00) && (is_sub ? sreg[`CAL_FLAG_Z] : 1'b1);
    else
      flags8[`CAL_FLAG_Z] = (r8 == 8'h00);
    k6 = req.imm[5:0];
    word_sub = (req.op == CAL_OP_WORD_SUBTRACT_IMMEDIATE);
    r16 = word_sub ? 16'(req.pair - {10'h000, k6}) : 16'(req.pair + {10'h000, k6});
  end

  // ---------------------------------------------------------------
  // Sequencer and result registers
  // ---------------------------------------------------------------
  cal_state_t state_r, state_nxt;
  logic [15:0] hold_r, hold_nxt;
  logic [7:0] hold_flags_r, hold_flags_nxt;
  logic res_valid_r, res_valid_nxt;
  logic [15:0] res_data_r, res_data_nxt;
  logic res_wide_r, res_wide_nxt;
  logic [7:0] sreg_r, sreg_nxt;
  logic ready_r, ready_nxt;
  logic skip_r, skip_nxt;
  logic addr_err_r, addr_err_nxt;
  cal_io_wr_t io_wr_r, io_wr_nxt;
  logic [W1C_WIDTH-1:0] w1c_r, w1c_nxt;
  logic [7:0] wfl;
  logic [7:0] w1c_clr;

  // Word forms park their result for one cycle so they retire on the second edge
  always_comb begin
    state_nxt = state_r;
    hold_nxt = hold_r;
    hold_flags_nxt = hold_flags_r;
    res_valid_nxt = 1'b0;
    res_data_nxt = res_data_r;
    res_wide_nxt = res_wide_r;
    sreg_nxt = sreg_r;
    skip_nxt = 1'b0;
    addr_err_nxt = 1'b0;
    io_wr_nxt = '0;
    w1c_clr = 8'h00;
    wfl = sreg_r;
    wfl[`CAL_FLAG_N] = r16[15];
    wfl[`CAL_FLAG_V] = word_sub ? (req.pair[15] & ~r16[15]) : (~req.pair[15] & r16[15]);
    wfl[`CAL_FLAG_C] = word_sub ? (r16[15] & ~req.pair[15]) : (~r16[15] & req.pair[15]);
    wfl[`CAL_FLAG_S] = wfl[`CAL_FLAG_N] ^ wfl[`CAL_FLAG_V];
    wfl[`CAL_FLAG_Z] = (r16 == 16'h0000);
    if (state_r == CAL_ST_WORD2) begin
      state_nxt = CAL_ST_IDLE;
      res_valid_nxt = 1'b1;
      res_wide_nxt = 1'b1;
      res_data_nxt = hold_r;
      sreg_nxt = hold_flags_r;
    end else if (take) begin
      res_wide_nxt = 1'b0;
      if (is_byte_arith) begin
        res_valid_nxt = 1'b1;
        res_data_nxt = {8'h00, r8};
        sreg_nxt = flags8;
      end else begin
        case (req.op)
          CAL_OP_WORD_ADD_IMMEDIATE, CAL_OP_WORD_SUBTRACT_IMMEDIATE: begin
            state_nxt = CAL_ST_WORD2;
            hold_nxt = r16;
            hold_flags_nxt = wfl;
          end
          CAL_OP_AND, CAL_OP_AND_IMMEDIATE: begin
            res_valid_nxt = 1'b1;
            res_data_nxt = {8'h00, req.rd & ((req.op == CAL_OP_AND) ? req.rr : req.imm)};
            sreg_nxt[`CAL_FLAG_V] = 1'b0;
            sreg_nxt[`CAL_FLAG_N] = res_data_nxt[7];
            sreg_nxt[`CAL_FLAG_Z] = (res_data_nxt[7:0] == 8'h00);
          end
          CAL_OP_IO_BIT_SET, CAL_OP_IO_BIT_CLEAR: begin
            res_valid_nxt = 1'b1;
            addr_err_nxt = !bit_ok;
            // A single lane mask keeps neighbouring flags out of the write
            io_wr_nxt.en = bit_ok;
            io_wr_nxt.addr = port;
            io_wr_nxt.mask = bit_mask;
            io_wr_nxt.data = (req.op == CAL_OP_IO_BIT_SET) ? bit_mask : 8'h00;
            if (bit_ok && port == `CAL_W1C_PORT && req.op == CAL_OP_IO_BIT_SET) w1c_clr = bit_mask;
          end
          CAL_OP_SKIP_IF_IO_BIT_ONE, CAL_OP_SKIP_IF_IO_BIT_ZERO: begin
            res_valid_nxt = 1'b1;
            addr_err_nxt = !bit_ok;
            skip_nxt = bit_ok && ((io_val[req.bit_sel] == 1'b1) == (req.op == CAL_OP_SKIP_IF_IO_BIT_ONE));
          end
          CAL_OP_PORT_IN, CAL_OP_DATA_SPACE_LOAD: begin
            res_valid_nxt = 1'b1;
            addr_err_nxt = !port_ok;
            res_data_nxt = port_ok ? {8'h00, io_val} : 16'h0000;
          end
          CAL_OP_PORT_OUT, CAL_OP_DATA_SPACE_STORE: begin
            res_valid_nxt = 1'b1;
            addr_err_nxt = !port_ok;
            io_wr_nxt.en = port_ok;
            io_wr_nxt.addr = port;
            io_wr_nxt.mask = 8'hff;
            io_wr_nxt.data = req.rd;
            if (port_ok && port == `CAL_W1C_PORT) w1c_clr = req.rd;
          end
          default: addr_err_nxt = 1'b1;
        endcase
      end
    end
    // Ready is kept in its own flop so the port does not hang off a decoder
    ready_nxt = (state_nxt == CAL_ST_IDLE);
    // New events win over a clear in the same cycle
    w1c_nxt = (w1c_r & ~w1c_clr[W1C_WIDTH-1:0]) | w1c_set;
  end

  // Registers only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= CAL_ST_IDLE;
      hold_r <= 16'h0000;
      hold_flags_r <= `CAL_SREG_RST;
      res_valid_r <= 1'b0;
      res_data_r <= 16'h0000;
      res_wide_r <= 1'b0;
      sreg_r <= `CAL_SREG_RST;
      ready_r <= 1'b1;
      skip_r <= 1'b0;
      addr_err_r <= 1'b0;
      io_wr_r <= '0;
      w1c_r <= W1C_WIDTH'(`CAL_W1C_RST);
    end else begin
      state_r <= state_nxt;
      hold_r <= hold_nxt;
      hold_flags_r <= hold_flags_nxt;
      res_valid_r <= res_valid_nxt;
      res_data_r <= res_data_nxt;
      res_wide_r <= res_wide_nxt;
      sreg_r <= sreg_nxt;
      ready_r <= ready_nxt;
      skip_r <= skip_nxt;
      addr_err_r <= addr_err_nxt;
      io_wr_r <= io_wr_nxt;
      w1c_r <= w1c_nxt;
    end
  end

  // Outputs straight from flops; ready drops while a word form is in flight
  assign req_ready = ready_r;
  assign res_valid = res_valid_r;
  assign res_data = res_data_r;
  assign res_wide = res_wide_r;
  assign sreg = sreg_r;
  assign skip = skip_r;
  assign addr_err = addr_err_r;
  assign io_wr = io_wr_r;
  assign w1c_flags = w1c_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  byte_one_cycle_a: assert property (take && is_byte_arith |=> res_valid && !res_wide)
    else $error("byte arithmetic did not retire in one cycle");
  sub_result_a: assert property (take && req.op == CAL_OP_SUB |=> res_data[7:0] == 8'($past(req.rd) - $past(req.rr)))
    else $error("subtract result wrong");
  subtract_immediate_carry_a: assert property (take && req.op == CAL_OP_SUBTRACT_IMMEDIATE
      |=> sreg[`CAL_FLAG_C] == ($past(req.rd) < $past(req.imm)))
    else $error("subtract immediate borrow wrong");
  word_two_cycle_a: assert property (take && (req.op == CAL_OP_WORD_ADD_IMMEDIATE || req.op == CAL_OP_WORD_SUBTRACT_IMMEDIATE)
      |=> !req_ready && !res_valid ##1 res_valid && res_wide && req_ready)
    else $error("word form did not take two cycles");
  and_flags_a: assert property (take && req.op == CAL_OP_AND_IMMEDIATE
      |=> !sreg[`CAL_FLAG_V] && sreg[`CAL_FLAG_C] == $past(sreg[`CAL_FLAG_C]) && sreg[`CAL_FLAG_H] == $past(sreg[`CAL_FLAG_H]))
    else $error("and changed an unlisted flag");
  bit_range_a: assert property (take && req.op == CAL_OP_IO_BIT_SET && req.addr > 8'h1f |=> !io_wr.en && addr_err)
    else $error("bit set outside low range");
  one_lane_a: assert property (io_wr.en && $past(take && (req.op == CAL_OP_IO_BIT_SET || req.op == CAL_OP_IO_BIT_CLEAR))
      |-> $onehot(io_wr.mask))
    else $error("bit write touched more than one bit");
  w1c_clear_a: assert property (take && req.op == CAL_OP_PORT_OUT && req.addr == {2'b00, `CAL_W1C_PORT} && req.rd[0] && !w1c_set[0]
      |=> !w1c_flags[0])
    else $error("writing one did not clear flag");
  ds_offset_a: assert property (take && req.op == CAL_OP_DATA_SPACE_STORE && req.addr == 8'h5f
      |=> io_wr.en && io_wr.addr == 6'h3f)
    else $error("data-space rebase wrong");

  word_cov_c: cover property (take && req.op == CAL_OP_WORD_SUBTRACT_IMMEDIATE ##2 res_valid);
  skip_cov_c: cover property (take && req.op == CAL_OP_SKIP_IF_IO_BIT_ZERO ##1 skip);
  w1c_cov_c: cover property (take && req.op == CAL_OP_IO_BIT_SET && req.addr == {2'b00, `CAL_W1C_PORT});
  adc_cov_c: cover property (take && req.op == CAL_OP_ADC && sreg[`CAL_FLAG_C]);

endmodule // cal_alu_io

// >>> cal_alu_map.svh
// Constants of the execute-stage ALU and I/O bit access block
`ifndef CAL_ALU_MAP_SVH
`define CAL_ALU_MAP_SVH

// Status register bit positions
`define CAL_FLAG_C 3'd0
`define CAL_FLAG_Z 3'd1
`define CAL_FLAG_N 3'd2
`define CAL_FLAG_V 3'd3
`define CAL_FLAG_S 3'd4
`define CAL_FLAG_H 3'd5
`define CAL_SREG_RST 8'h00

// I/O address space
`define CAL_IO_BIT_LAST 6'h1f
`define CAL_IO_PORT_LAST 6'h3f
`define CAL_IO_DS_OFFSET 8'h20
`define CAL_IO_DS_LAST 8'h5f

// Write-one-to-clear flag register placed in the bit-accessible range
`define CAL_W1C_PORT 6'h08
`define CAL_W1C_RST 8'h00

// Cycle counts
`define CAL_BYTE_CYCLES 1
`define CAL_WORD_CYCLES 2

`endif

// >>> cal_alu_pkg.sv
// Types of the execute-stage ALU and I/O bit access block
package cal_alu_pkg;

  typedef enum logic [4:0] {
    CAL_OP_ADD = 5'h00,
    CAL_OP_ADC = 5'h01,
    CAL_OP_SUB = 5'h02,
    CAL_OP_SUBTRACT_WITH_CARRY = 5'h03,
    CAL_OP_SUBTRACT_IMMEDIATE = 5'h04,
    CAL_OP_SUBTRACT_IMMEDIATE_WITH_CARRY = 5'h05,
    CAL_OP_WORD_ADD_IMMEDIATE = 5'h06,
    CAL_OP_WORD_SUBTRACT_IMMEDIATE = 5'h07,
    CAL_OP_AND = 5'h08,
    CAL_OP_AND_IMMEDIATE = 5'h09,
    CAL_OP_IO_BIT_SET = 5'h0a,
    CAL_OP_IO_BIT_CLEAR = 5'h0b,
    CAL_OP_SKIP_IF_IO_BIT_ONE = 5'h0c,
    CAL_OP_SKIP_IF_IO_BIT_ZERO = 5'h0d,
    CAL_OP_PORT_IN = 5'h0e,
    CAL_OP_PORT_OUT = 5'h0f,
    CAL_OP_DATA_SPACE_LOAD = 5'h10,
    CAL_OP_DATA_SPACE_STORE = 5'h11
  } cal_op_t;

  // One decoded instruction with its operands
  typedef struct packed {
    cal_op_t op;
    logic [7:0] rd;
    logic [7:0] rr;
    logic [7:0] imm;
    logic [15:0] pair;
    logic [7:0] addr;
    logic [2:0] bit_sel;
  } cal_req_t;

  // One write toward the I/O register space
  typedef struct packed {
    logic en;
    logic [5:0] addr;
    logic [7:0] data;
    logic [7:0] mask;
  } cal_io_wr_t;

  typedef enum logic {
    CAL_ST_IDLE = 1'b0,
    CAL_ST_WORD2 = 1'b1
  } cal_state_t;

endpackage

// >>> cal_io_space_model.sv
// Behavioural model of the I/O register space that sits behind the decoder
`timescale 1ns/1ns
`include "cal_alu_map.svh"
module cal_io_space_model
  import cal_alu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Request and write as seen at the decoder
  input wire cal_req_t req,
  input wire cal_io_wr_t io_wr,
  // Read side
  output logic [7:0] io_rd_data,
  output logic rsvd_hit
);
  logic [7:0] regs_r [64];
  logic [7:0] port;

  // Load forms carry a data-space address, so the offset comes back off
  always_comb begin
    port = (req.op == CAL_OP_DATA_SPACE_LOAD) ? req.addr - `CAL_IO_DS_OFFSET : req.addr;
    io_rd_data = regs_r[port[5:0]];
  end

  // Non-zero reset pattern so a read of the wrong port shows up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 64; i++) begin
        regs_r[i] <= 8'(i) ^ 8'h5a;
      end
      rsvd_hit <= 1'b0;
    end else if (io_wr.en) begin
      regs_r[io_wr.addr] <= (regs_r[io_wr.addr] & ~io_wr.mask) | (io_wr.data & io_wr.mask);
      rsvd_hit <= rsvd_hit | (io_wr.addr == 6'h00) | (io_wr.addr inside {[6'h04:6'h07]});
    end
  end
endmodule // cal_io_space_model

// >>> test_cal_alu_io.sv
// Self-checking bench of the ALU and I/O bit access block
`timescale 1ns/1ns
`include "cal_alu_map.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module test_cal_alu_io
  import cal_alu_pkg::*;
;
  typedef struct packed {
    cal_op_t op;
    logic [7:0] rd;
    logic [7:0] rr;
    logic [7:0] imm;
    logic [15:0] pair;
    logic [15:0] res;
    logic [7:0] flags;
  } cal_row_t;

  logic clk, rstn, req_valid, req_ready, res_valid, res_wide, skip, addr_err, rsvd_hit, rdy, w;
  logic [7:0] io_rd_data, sreg, w1c_set, w1c_flags;
  logic [15:0] res_data;
  cal_req_t req;
  cal_io_wr_t io_wr, wr;
  int num_errors, tests_run, lat, npul;
  // Rows run in order: flags carry from one row into the next
  cal_row_t rows [15] = '{
    '{CAL_OP_ADD, 8'hff, 8'h01, 8'h00, 16'h0000, 16'h0000, 8'h23},
    '{CAL_OP_ADC, 8'h7f, 8'h00, 8'h00, 16'h0000, 16'h0080, 8'h2c},
    '{CAL_OP_SUB, 8'h05, 8'h07, 8'h00, 16'h0000, 16'h00fe, 8'h25},
    '{CAL_OP_SUBTRACT_WITH_CARRY, 8'h10, 8'h0f, 8'h00, 16'h0000, 16'h0000, 8'h20},
    '{CAL_OP_SUB, 8'h03, 8'h03, 8'h00, 16'h0000, 16'h0000, 8'h02},
    '{CAL_OP_SUBTRACT_IMMEDIATE_WITH_CARRY, 8'h00, 8'h00, 8'h00, 16'h0000, 16'h0000, 8'h02},
    '{CAL_OP_SUBTRACT_IMMEDIATE, 8'h80, 8'h00, 8'h01, 16'h0000, 16'h007f, 8'h28},
    '{CAL_OP_SUBTRACT_IMMEDIATE_WITH_CARRY, 8'h00, 8'h00, 8'h01, 16'h0000, 16'h00ff, 8'h25},
    '{CAL_OP_AND, 8'hf0, 8'h3c, 8'h00, 16'h0000, 16'h0030, 8'h21},
    '{CAL_OP_AND_IMMEDIATE, 8'h0f, 8'h00, 8'hf0, 16'h0000, 16'h0000, 8'h23},
    '{CAL_OP_WORD_ADD_IMMEDIATE, 8'h00, 8'h00, 8'h01, 16'hffff, 16'h0000, 8'h23},
    '{CAL_OP_WORD_ADD_IMMEDIATE, 8'h00, 8'h00, 8'h01, 16'h7fff, 16'h8000, 8'h2c},
    '{CAL_OP_WORD_SUBTRACT_IMMEDIATE, 8'h00, 8'h00, 8'h01, 16'h0000, 16'hffff, 8'h35},
    '{CAL_OP_ADD, 8'h01, 8'h01, 8'h00, 16'h0000, 16'h0002, 8'h10},
    '{CAL_OP_WORD_SUBTRACT_IMMEDIATE, 8'h00, 8'h00, 8'hff, 16'h0040, 16'h0001, 8'h00}
  };

  cal_alu_io cal_alu_io_inst (.clk, .rstn, .req_valid, .req, .io_rd_data, .req_ready, .res_valid, .res_data,
    .res_wide, .sreg, .skip, .addr_err, .io_wr, .w1c_set, .w1c_flags);
  cal_io_space_model cal_io_space_model_inst (.clk, .rstn, .req, .io_wr, .io_rd_data, .rsvd_hit);

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // One request, held until its taking edge, then wait a bounded time for retirement
  task automatic run(input cal_op_t op, input logic [7:0] rd, rr, imm, input logic [15:0] pair,
                     input logic [7:0] addr, input logic [2:0] b);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op, rd, rr, imm, pair, addr, b};
    @(posedge clk);
    req_valid <= 1'b0;
    #1 rdy = req_ready;
    lat = 0;
    while (res_valid !== 1'b1 && lat < 4) begin
      @(posedge clk);
      #1 lat++;
    end
    wr = io_wr;
  endtask

  task automatic io(input cal_op_t op, input logic [7:0] rd, addr, input logic [2:0] b);
    run(op, rd, 8'h00, 8'h00, 16'h0000, addr, b);
  endtask

  task automatic chk_rst;
    `CHK("reset_state", {1'b1, 1'b0, `CAL_SREG_RST, `CAL_W1C_RST}, {req_ready, res_valid, sreg, w1c_flags});
  endtask

  task automatic wrap_up;
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog: the whole sequence needs about a hundred cycles
  initial begin
    #8000;
    num_errors++;
    wrap_up;
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    w1c_set = 8'h00;
    num_errors = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    #1 chk_rst();
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].rd, rows[i].rr, rows[i].imm, rows[i].pair, 8'h00, 3'd0);
      w = rows[i].op inside {CAL_OP_WORD_ADD_IMMEDIATE, CAL_OP_WORD_SUBTRACT_IMMEDIATE};
      `CHK("res_data", rows[i].res, res_data);
      `CHK("sreg", rows[i].flags, sreg);
      `CHK("wide_ready", {w, !w}, {res_wide, rdy});
      `CHK("latency", (w ? `CAL_WORD_CYCLES : `CAL_BYTE_CYCLES) - 1, lat);
    end
    // Flag register: hardware sets, one-writes clear only the addressed flag
    @(posedge clk);
    w1c_set <= 8'h05;
    @(posedge clk);
    w1c_set <= 8'h00;
    io(CAL_OP_IO_BIT_SET, 8'h00, {2'b00, `CAL_W1C_PORT}, 3'd2);
    `CHK("io_wr", {1'b1, `CAL_W1C_PORT, 8'h04, 8'h04}, wr);
    `CHK("w1c_flags", 8'h01, w1c_flags);
    io(CAL_OP_IO_BIT_CLEAR, 8'h00, 8'h08, 3'd0);
    `CHK("io_wr", {1'b1, 6'h08, 8'h00, 8'h01}, wr);
    `CHK("w1c_flags", 8'h01, w1c_flags);
    io(CAL_OP_SKIP_IF_IO_BIT_ONE, 8'h00, 8'h08, 3'd0);
    `CHK("skip_err", 2'b10, {skip, addr_err});
    io(CAL_OP_PORT_OUT, 8'h00, 8'h08, 3'd0);
    `CHK("w1c_flags", 8'h01, w1c_flags);
    io(CAL_OP_DATA_SPACE_STORE, 8'h01, 8'h28, 3'd0);
    `CHK("io_wr", {1'b1, 6'h08, 8'h01, 8'hff}, wr);
    `CHK("w1c_flags", 8'h00, w1c_flags);
    io(CAL_OP_SKIP_IF_IO_BIT_ZERO, 8'h00, 8'h08, 3'd0);
    `CHK("skip_err", 2'b10, {skip, addr_err});
    // Ordinary port 0x12 starts at 0x48: bit 7 low, bit 6 high
    io(CAL_OP_SKIP_IF_IO_BIT_ONE, 8'h00, 8'h12, 3'd7);
    `CHK("skip_err", 2'b00, {skip, addr_err});
    io(CAL_OP_IO_BIT_SET, 8'h00, 8'h12, 3'd7);
    `CHK("io_wr", {1'b1, 6'h12, 8'h80, 8'h80}, wr);
    io(CAL_OP_SKIP_IF_IO_BIT_ONE, 8'h00, 8'h12, 3'd7);
    `CHK("skip_err", 2'b10, {skip, addr_err});
    io(CAL_OP_SKIP_IF_IO_BIT_ZERO, 8'h00, 8'h12, 3'd6);
    `CHK("skip_err", 2'b00, {skip, addr_err});
    io(CAL_OP_SKIP_IF_IO_BIT_ZERO, 8'h00, 8'h1f, 3'd1);
    `CHK("skip_err", 2'b10, {skip, addr_err});
    io(CAL_OP_IO_BIT_SET, 8'h00, 8'h20, 3'd0);
    `CHK("err_wr", 2'b10, {addr_err, wr.en});
    io(CAL_OP_SKIP_IF_IO_BIT_ONE, 8'h00, 8'h20, 3'd1);
    `CHK("skip_err", 2'b01, {skip, addr_err});
    // Port 0x15 has no reserved bits, so any byte may be written
    io(CAL_OP_PORT_OUT, 8'ha5, 8'h15, 3'd0);
    `CHK("io_wr", {1'b1, 6'h15, 8'ha5, 8'hff}, wr);
    io(CAL_OP_PORT_IN, 8'h00, 8'h15, 3'd0);
    `CHK("res_data", 16'h00a5, res_data);
    io(CAL_OP_DATA_SPACE_LOAD, 8'h00, 8'h35, 3'd0);
    `CHK("res_data", 16'h00a5, res_data);
    io(CAL_OP_PORT_IN, 8'h00, 8'h3f, 3'd0);
    `CHK("in_top", {1'b0, 16'h0065}, {addr_err, res_data});
    io(CAL_OP_PORT_IN, 8'h00, 8'h40, 3'd0);
    `CHK("in_over", {1'b1, 16'h0000}, {addr_err, res_data});
    io(CAL_OP_DATA_SPACE_LOAD, 8'h00, 8'h1f, 3'd0);
    `CHK("ld_under", 1'b1, addr_err);
    io(CAL_OP_DATA_SPACE_STORE, 8'h01, 8'h60, 3'd0);
    `CHK("err_wr", 2'b10, {addr_err, wr.en});
    // Byte request held through the bubble after a word form: taken once only
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{CAL_OP_WORD_ADD_IMMEDIATE, 8'h00, 8'h00, 8'h01, 16'h0001, 8'h00, 3'd0};
    @(posedge clk);
    req <= '{CAL_OP_ADD, 8'h01, 8'h01, 8'h00, 16'h0000, 8'h00, 3'd0};
    npul = 0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      if (i == 1) begin
        req_valid <= 1'b0;
      end
      #1 npul += int'(res_valid);
    end
    `CHK("pulses", 2, npul);
    `CHK("res_data", 16'h0002, res_data);
    // Checked before the reset below, which would clear it anyway
    `CHK("rsvd_hit", 1'b0, rsvd_hit);
    // Reset in mid-run
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    #1 chk_rst();
    rstn <= 1'b1;
    wrap_up;
  end
endmodule // test_cal_alu_io
